// ### logic/afdc_pkg.sv
`default_nettype none
package afdc_pkg;

  localparam int SMP_W = 24;
  localparam int ACC_W = 56;
  localparam int CNT_W = 32;
  localparam int EXP_W = 6;
  localparam int PWR_W = 5;
  localparam int NPATH = 4;
  localparam int ADDR_W = 12;

  localparam logic [EXP_W-1:0] EXP_MAX = 6'h1F;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_EST0   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_EST3   = 12'h01C;

  localparam int CTRL_MIN_LSB = 0;
  localparam int CTRL_LOW_LSB = 8;
  localparam int CTRL_UP_LSB  = 16;
  localparam int STAT_HOLD_LSB = 0;
  localparam int STAT_SEEN_LSB = 4;

  localparam logic [3:0]       MIN_RST = 4'h4;
  localparam logic [PWR_W-1:0] LOW_RST = 5'h08;
  localparam logic [PWR_W-1:0] UP_RST  = 5'h14;

  typedef logic signed [SMP_W-1:0] afdc_smp_t;

endpackage
`default_nettype wire

// ### logic/afdc_pwrenc.sv
`timescale 1ns/100ps
`default_nettype none
// Power word in 6 dB steps: index of the highest set magnitude bit plus one, zero for silence.
module afdc_pwrenc (
  input  wire logic [afdc_pkg::SMP_W-1:0] mag,
  output var  logic [afdc_pkg::PWR_W-1:0] pwr
);
  always_comb begin
    pwr = 5'h00;
    for (int i = 0; i < afdc_pkg::SMP_W; i++) begin
      if (mag[i]) begin
        pwr = 5'(i + 1);
      end
    end
  end
endmodule // afdc_pwrenc
`default_nettype wire

// ### logic/afdc_satsub.sv
`timescale 1ns/100ps
`default_nettype none
// Signed difference that clamps to the range limits instead of wrapping.
module afdc_satsub (
  input  wire logic signed [afdc_pkg::SMP_W-1:0] a,
  input  wire logic signed [afdc_pkg::SMP_W-1:0] b,
  output var  logic signed [afdc_pkg::SMP_W-1:0] y
);
  logic signed [afdc_pkg::SMP_W:0] diff;
  always_comb begin
    diff = {a[afdc_pkg::SMP_W-1], a} - {b[afdc_pkg::SMP_W-1], b};
    if (diff[afdc_pkg::SMP_W] != diff[afdc_pkg::SMP_W-1]) begin
      y = diff[afdc_pkg::SMP_W] ? 24'h800000 : 24'h7FFFFF;
    end else begin
      y = diff[afdc_pkg::SMP_W-1:0];
    end
  end
endmodule // afdc_satsub
`default_nettype wire

// ### logic/afdc_top.sv
//
// Behaviour
// - Sits between coefficient filter and serial port, correcting every sample continuously.
// - Accumulate samples until counter zero, then load accumulator with new sample.
// - Subtract held estimate from each sample with saturation, never wrap; an expiry sample gets the estimate it produces.
// - Four paths each own peak, accumulator, subtractor and counter; only the threshold and minimum-period settings are shared.
// - First sample preloads peak with its magnitude, counter with minimum period.
// - Each sample's magnitude replaces the held peak when larger.
// - Counter zero moves accumulator to estimate, restarts accumulator, reloads peak.
// - Peak is encoded into a power word counting 6 dB steps.
// - Below lower threshold, counter cycles at minimum period, updating each expiry.
// - Above upper threshold, counter held at minimum period, no update; an expiry due on that sample is still served and updates.
// - Above upper threshold, estimate in progress discarded, held estimate still used.
// - Back below upper threshold, counting resumes with a fresh accumulation.
// - Between thresholds, each 6 dB rise multiplies the period by four.
// - Period is two to the minimum plus twice the capped excess.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module afdc_top (
  input  wire logic                              CLOCK,
  input  wire logic                              RST_N,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [afdc_pkg::ADDR_W-1:0]       PADDR,
  input  wire logic [31:0]                       PWDATA,
  output var  logic [31:0]                       PRDATA,
  output var  logic                              PREADY,
  output var  logic                              PSLVERR,
  input  wire logic                              IN_VALID,
  input  wire logic signed [afdc_pkg::SMP_W-1:0] IN_CHAN_A_INPHASE,
  input  wire logic signed [afdc_pkg::SMP_W-1:0] IN_CHAN_A_QUADRATURE,
  input  wire logic signed [afdc_pkg::SMP_W-1:0] IN_CHAN_B_INPHASE,
  input  wire logic signed [afdc_pkg::SMP_W-1:0] IN_CHAN_B_QUADRATURE,
  output var  logic                              OUT_VALID,
  output var  logic signed [afdc_pkg::SMP_W-1:0] OUT_CHAN_A_INPHASE,
  output var  logic signed [afdc_pkg::SMP_W-1:0] OUT_CHAN_A_QUADRATURE,
  output var  logic signed [afdc_pkg::SMP_W-1:0] OUT_CHAN_B_INPHASE,
  output var  logic signed [afdc_pkg::SMP_W-1:0] OUT_CHAN_B_QUADRATURE
);

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [3:0]                    min_q,  min_d;
  logic [afdc_pkg::PWR_W-1:0]    low_q,  low_d;
  logic [afdc_pkg::PWR_W-1:0]    up_q,   up_d;
  logic [31:0]                   prdata_q, prdata_d;
  logic                          pready_q, pready_d;
  logic                          pslverr_q, pslverr_d;
  logic                          valid_q;
  afdc_pkg::afdc_smp_t           in_smp   [afdc_pkg::NPATH];
  afdc_pkg::afdc_smp_t           out_q    [afdc_pkg::NPATH];
  afdc_pkg::afdc_smp_t           out_d    [afdc_pkg::NPATH];
  afdc_pkg::afdc_smp_t           est_q    [afdc_pkg::NPATH];
  logic [afdc_pkg::NPATH-1:0]    hold_q;
  logic [afdc_pkg::NPATH-1:0]    seen_q;

  assign in_smp[0] = IN_CHAN_A_INPHASE;
  assign in_smp[1] = IN_CHAN_A_QUADRATURE;
  assign in_smp[2] = IN_CHAN_B_INPHASE;
  assign in_smp[3] = IN_CHAN_B_QUADRATURE;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Register slave. Zero wait states: the answer is prepared in the setup cycle.

  logic [2:0] est_idx;

  always_comb begin
    min_d     = min_q;
    low_d     = low_q;
    up_d      = up_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    est_idx   = 3'(PADDR[4:2]);
    if (PSEL && !PENABLE) begin
      pready_d = 1'b1;
      prdata_d = 32'h00000000;
      if (PADDR == afdc_pkg::OFF_CTRL) begin
        prdata_d[afdc_pkg::CTRL_MIN_LSB +: 4]                 = min_q;
        prdata_d[afdc_pkg::CTRL_LOW_LSB +: afdc_pkg::PWR_W]   = low_q;
        prdata_d[afdc_pkg::CTRL_UP_LSB +: afdc_pkg::PWR_W]    = up_q;
      end else if (PADDR == afdc_pkg::OFF_STATUS) begin
        prdata_d[afdc_pkg::STAT_HOLD_LSB +: afdc_pkg::NPATH]  = hold_q;
        prdata_d[afdc_pkg::STAT_SEEN_LSB +: afdc_pkg::NPATH]  = seen_q;
      end else if (PADDR >= afdc_pkg::OFF_EST0 && PADDR <= afdc_pkg::OFF_EST3 &&
                   PADDR[1:0] == 2'h0) begin
        prdata_d = {{(32 - afdc_pkg::SMP_W){est_q[est_idx[1:0]][afdc_pkg::SMP_W-1]}},
                    est_q[est_idx[1:0]]};
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // Writes land only at the completing access edge.
    if (PSEL && PENABLE && pready_q && PWRITE && PADDR == afdc_pkg::OFF_CTRL) begin
      min_d = PWDATA[afdc_pkg::CTRL_MIN_LSB +: 4];
      low_d = PWDATA[afdc_pkg::CTRL_LOW_LSB +: afdc_pkg::PWR_W];
      up_d  = PWDATA[afdc_pkg::CTRL_UP_LSB +: afdc_pkg::PWR_W];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      min_q     <= afdc_pkg::MIN_RST;
      low_q     <= afdc_pkg::LOW_RST;
      up_q      <= afdc_pkg::UP_RST;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      min_q     <= min_d;
      low_q     <= low_d;
      up_q      <= up_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Threshold span, shared settings only; every path keeps its own state.

  logic [afdc_pkg::PWR_W-1:0] span;
  logic [afdc_pkg::CNT_W-1:0] min_len;

  always_comb begin
    span    = (up_q > low_q) ? 5'(up_q - low_q) : 5'h00;
    min_len = 32'h00000001 << min_q;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // One correction path per stream.

  // What a path does with the sample in hand; unused codes fall back to idle.
  typedef enum logic [2:0] {
    ACT_IDLE  = 3'b000,
    ACT_FIRST = 3'b001,
    ACT_DUMP  = 3'b010,
    ACT_HOLD  = 3'b011,
    ACT_RUN   = 3'b100
  } afdc_act_t;

  for (genvar p = 0; p < afdc_pkg::NPATH; p++) begin : g_path
    logic signed [afdc_pkg::ACC_W-1:0] acc_q, acc_d;
    logic [afdc_pkg::SMP_W-1:0]        peak_q, peak_d;
    logic [afdc_pkg::CNT_W-1:0]        cnt_q, cnt_d;
    logic [afdc_pkg::EXP_W-1:0]        exp_q, exp_d;
    afdc_pkg::afdc_smp_t               est_d;
    logic                              hold_d, seen_d;
    logic [afdc_pkg::SMP_W-1:0]        mag, peak_new;
    logic [afdc_pkg::PWR_W-1:0]        pwr, excess;
    logic [afdc_pkg::EXP_W-1:0]        exp_new;
    logic signed [afdc_pkg::ACC_W-1:0] smp_ext, shifted;
    afdc_pkg::afdc_smp_t               diff;

    afdc_pwrenc u_enc (
      .mag (peak_new),
      .pwr (pwr)
    );

    afdc_satsub u_sub (
      .a (in_smp[p]),
      .b (est_d),
      .y (diff)
    );

    // An expiry is served before the threshold test, so a finished estimate is never lost.
    afdc_act_t act;

    always_comb begin
      act = ACT_IDLE;
      if (IN_VALID) begin
        if (!seen_q[p]) begin
          act = ACT_FIRST;
        end else if (cnt_q == 32'h00000000) begin
          act = ACT_DUMP;
        end else if (pwr > up_q) begin
          act = ACT_HOLD;
        end else begin
          act = ACT_RUN;
        end
      end
    end

    always_comb begin
      smp_ext  = {{(afdc_pkg::ACC_W - afdc_pkg::SMP_W){in_smp[p][afdc_pkg::SMP_W-1]}},
                  in_smp[p]};
      mag      = in_smp[p][afdc_pkg::SMP_W-1] ? 24'(~in_smp[p] + 24'h000001) : in_smp[p];
      peak_new = (mag > peak_q) ? mag : peak_q;
      excess   = (pwr > low_q) ? 5'(pwr - low_q) : 5'h00;
      if (excess > span) begin
        excess = span;
      end
      exp_new  = 6'({2'h0, min_q} + {excess, 1'b0});
      if (exp_new > afdc_pkg::EXP_MAX) begin
        exp_new = afdc_pkg::EXP_MAX;
      end
      shifted  = acc_q >>> exp_q;
    end

    always_comb begin
      unique case (act)
        ACT_IDLE:  acc_d = acc_q;
        ACT_FIRST: acc_d = smp_ext;
        ACT_DUMP:  acc_d = smp_ext;
        ACT_HOLD:  acc_d = smp_ext;
        ACT_RUN:   acc_d = acc_q + smp_ext;
        default:   acc_d = acc_q;
      endcase
    end

    // Peak is re-seeded each held sample, or a single burst would lock the path forever.
    always_comb begin
      unique case (act)
        ACT_IDLE:  peak_d = peak_q;
        ACT_FIRST: peak_d = mag;
        ACT_DUMP:  peak_d = mag;
        ACT_HOLD:  peak_d = mag;
        ACT_RUN:   peak_d = peak_new;
        default:   peak_d = peak_q;
      endcase
    end

    always_comb begin
      cnt_d = cnt_q;
      exp_d = exp_q;
      unique case (act)
        ACT_IDLE: begin
          cnt_d = cnt_q;
        end
        ACT_FIRST, ACT_DUMP: begin
          cnt_d = min_len - 32'h00000001;
          exp_d = 6'(min_q);
        end
        ACT_HOLD: begin
          cnt_d = min_len - 32'h00000001;
          exp_d = 6'(min_q);
        end
        ACT_RUN: begin
          if (exp_new > exp_q) begin
            // Remaining count grows by the difference, so the window reaches four times per step.
            cnt_d = cnt_q + (32'h00000001 << exp_new) - (32'h00000001 << exp_q) - 32'h00000001;
            exp_d = exp_new;
          end else begin
            cnt_d = cnt_q - 32'h00000001;
          end
        end
        default: begin
          cnt_d = cnt_q;
        end
      endcase
    end

    always_comb begin
      unique case (act)
        ACT_IDLE:  est_d = est_q[p];
        ACT_FIRST: est_d = est_q[p];
        ACT_DUMP:  est_d = shifted[afdc_pkg::SMP_W-1:0];
        ACT_HOLD:  est_d = est_q[p];
        ACT_RUN:   est_d = est_q[p];
        default:   est_d = est_q[p];
      endcase
    end

    always_comb begin
      seen_d = seen_q[p];
      hold_d = hold_q[p];
      unique case (act)
        ACT_IDLE: begin
          hold_d = hold_q[p];
        end
        ACT_FIRST: begin
          seen_d = 1'b1;
          hold_d = 1'b0;
        end
        ACT_DUMP: begin
          hold_d = 1'b0;
        end
        ACT_HOLD: begin
          hold_d = 1'b1;
        end
        ACT_RUN: begin
          hold_d = 1'b0;
        end
        default: begin
          hold_d = hold_q[p];
        end
      endcase
    end

    // The estimate that this very sample produces is already the one subtracted.
    always_comb begin
      out_d[p] = out_q[p];
      if (IN_VALID) begin
        out_d[p] = diff;
      end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        acc_q  <= 56'h00000000000000;
        peak_q <= 24'h000000;
        cnt_q  <= 32'h00000000;
        exp_q  <= 6'h00;
      end else begin
        acc_q  <= acc_d;
        peak_q <= peak_d;
        cnt_q  <= cnt_d;
        exp_q  <= exp_d;
      end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        est_q[p] <= 24'h000000;
      end else begin
        est_q[p] <= est_d;
      end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        hold_q[p] <= 1'b0;
        seen_q[p] <= 1'b0;
        out_q[p]  <= 24'h000000;
      end else begin
        hold_q[p] <= hold_d;
        seen_q[p] <= seen_d;
        out_q[p]  <= out_d[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= IN_VALID;
    end
  end

  assign OUT_VALID             = valid_q;
  assign OUT_CHAN_A_INPHASE    = out_q[0];
  assign OUT_CHAN_A_QUADRATURE = out_q[1];
  assign OUT_CHAN_B_INPHASE    = out_q[2];
  assign OUT_CHAN_B_QUADRATURE = out_q[3];

endmodule // afdc_top
`default_nettype wire

// ### testbench/afdc_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module afdc_top_sva (
  input wire logic               CLOCK,
  input wire logic               RST_N,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               IN_VALID,
  input wire logic signed [23:0] IN_CHAN_A_INPHASE,
  input wire logic               OUT_VALID,
  input wire logic signed [23:0] OUT_CHAN_A_INPHASE
);
  logic seen_q;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      seen_q <= 1'b0;
    end else if (IN_VALID) begin
      seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////
  property p_lat; IN_VALID |=> OUT_VALID; endproperty
  a_lat: assert property (p_lat)
    else $error("sample not answered one cycle later");
  property p_idle; !IN_VALID |=> !OUT_VALID; endproperty
  a_idle: assert property (p_idle)
    else $error("output strobe without a sample");
  property p_hold; !IN_VALID |=> $stable(OUT_CHAN_A_INPHASE); endproperty
  a_hold: assert property (p_hold)
    else $error("output moved without a sample");
  property p_first;
    IN_VALID && !seen_q |=> OUT_CHAN_A_INPHASE == $past(IN_CHAN_A_INPHASE);
  endproperty
  a_first: assert property (p_first)
    else $error("first sample was corrected");
  property p_satp; IN_VALID && IN_CHAN_A_INPHASE == 24'h7FFFFF |=> !OUT_CHAN_A_INPHASE[23]; endproperty
  a_satp: assert property (p_satp)
    else $error("positive full scale wrapped");
  property p_satn;
    IN_VALID && IN_CHAN_A_INPHASE == 24'h800000 |=> OUT_CHAN_A_INPHASE[23] || OUT_CHAN_A_INPHASE == 24'h000000;
  endproperty
  a_satn: assert property (p_satn)
    else $error("negative full scale wrapped");
  property p_rst; $rose(RST_N) |-> !OUT_VALID && OUT_CHAN_A_INPHASE == 24'h000000; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  property p_rdy; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
  a_rdy: assert property (p_rdy)
    else $error("bus answer not a single cycle after setup");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err)
    else $error("error flag outside the answer cycle");
  c_first: cover property (IN_VALID && !seen_q);
  c_err: cover property (PSLVERR);
  c_sat: cover property (IN_VALID && IN_CHAN_A_INPHASE == 24'h800000);
endmodule // afdc_top_sva
bind afdc_top afdc_top_sva i_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IN_VALID(IN_VALID), .IN_CHAN_A_INPHASE(IN_CHAN_A_INPHASE),
  .OUT_VALID(OUT_VALID), .OUT_CHAN_A_INPHASE(OUT_CHAN_A_INPHASE)
);
`default_nettype wire

// ### testbench/afdc_src.sv
`timescale 1ns/100ps
`default_nettype none
module afdc_src (
  input  wire logic                            clk,
  output var  logic                            valid,
  output var  logic [3:0][afdc_pkg::SMP_W-1:0] smp
);
  // Software keeps the composite gain at unity, so only plain 24-bit words are offered.
  initial begin
    valid = 1'b0;
    smp = '0;
  end
  // Between samples the lines carry the inverse of the last word, so a stale copy never helps.
  task automatic send(input logic [3:0][afdc_pkg::SMP_W-1:0] v);
    @(posedge clk);
    valid <= 1'b1;
    smp <= v;
    @(posedge clk);
    valid <= 1'b0;
    smp <= ~v;
  endtask
endmodule // afdc_src
`default_nettype wire

// ### testbench/afdc_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module afdc_top_test;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         rd;
  logic                er;
  wire logic [31:0]    prdata;
  wire logic           pready;
  wire logic           pslverr;
  wire logic           in_valid;
  wire logic           out_valid;
  wire logic [3:0][23:0] src_d;
  wire logic [3:0][23:0] outs;
  int                  num_errors = 0;
  int                  total_checks = 0;
  afdc_pkg::afdc_smp_t x [4];
  afdc_pkg::afdc_smp_t est_m [4];
  always #2.5 clock = ~clock;
  afdc_src i_src (.clk(clock), .valid(in_valid), .smp(src_d));
  afdc_top i_dut (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IN_VALID(in_valid), .IN_CHAN_A_INPHASE(src_d[0]), .IN_CHAN_A_QUADRATURE(src_d[1]),
    .IN_CHAN_B_INPHASE(src_d[2]), .IN_CHAN_B_QUADRATURE(src_d[3]), .OUT_VALID(out_valid),
    .OUT_CHAN_A_INPHASE(outs[0]), .OUT_CHAN_A_QUADRATURE(outs[1]),
    .OUT_CHAN_B_INPHASE(outs[2]), .OUT_CHAN_B_QUADRATURE(outs[3])
  );
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic afdc_pkg::afdc_smp_t sat(input afdc_pkg::afdc_smp_t a, input afdc_pkg::afdc_smp_t b);
    logic signed [24:0] d;
    d = a - b;
    sat = (d > 25'sh07FFFFF) ? 24'h7FFFFF : (d < -25'sh0800000) ? 24'h800000 : d[23:0];
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", 32'(ee), 32'(er));
  endtask
  task automatic sample_io();
    int i;
    i_src.send({x[3], x[2], x[1], x[0]});
    #1;
    chk("out_valid", 32'h1, 32'(out_valid));
    for (i = 0; i < 4; i++) begin
      chk("out_path", {8'h00, sat(x[i], est_m[i])}, {8'h00, outs[i]});
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
  initial begin
    int i;
    int k;
    est_m = '{default: '0};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(afdc_pkg::OFF_CTRL, 32'h00140804, 1'b0);
    for (i = 0; i < 6; i++) rdchk(afdc_pkg::OFF_STATUS + 12'(4 * i), 32'h0, i == 1 || i == 2);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk("wr_err", 32'h1, 32'(er));
    apb(1'b1, afdc_pkg::OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b1, afdc_pkg::OFF_CTRL, 32'h00140802);
    rdchk(afdc_pkg::OFF_CTRL, 32'h00140802, 1'b0);
    rdchk(afdc_pkg::OFF_STATUS, 32'h0, 1'b0);
    x = '{24'sh000005, -24'sh000003, 24'sh000064, -24'sh0000C8};
    for (k = 0; k < 8; k++) begin
      if (k == 4) est_m = x;
      sample_io();
    end
    for (i = 0; i < 4; i++) rdchk(afdc_pkg::OFF_EST0 + 12'(4 * i), 32'(est_m[i]), 1'b0);
    rdchk(afdc_pkg::OFF_STATUS, 32'h000000F0, 1'b0);
    x[0] = 24'sh400000;
    repeat (3) sample_io();
    rdchk(afdc_pkg::OFF_STATUS, 32'h000000F1, 1'b0);
    rdchk(afdc_pkg::OFF_EST0, 32'h00000005, 1'b0);
    x[0] = 24'sh800000;
    x[1] = 24'sh7FFFFF;
    sample_io();
    x[0] = 24'sh7FFFFF;
    x[1] = 24'sh800000;
    sample_io();
    x[0] = 24'sh000009;
    x[1] = 24'sh000007;
    for (k = 0; k < 8; k++) begin
      if (k == 4) est_m[0:1] = x[0:1];
      sample_io();
    end
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    est_m = '{default: '0};
    apb(1'b1, afdc_pkg::OFF_CTRL, 32'h00140802);
    x = '{24'sh00012C, 24'sh000005, 24'sh00012C, -24'sh000006};
    for (k = 0; k < 18; k++) begin
      if (k == 4) est_m = '{est_m[0], x[1], est_m[2], x[3]};
      if (k == 16) est_m = x;
      sample_io();
    end
    wrap_up();
  end
endmodule // afdc_top_test
`default_nettype wire
